/* File: rtl/spm_pkg.sv */
// Constants and types for the per-port spanning tree, mirror and trunk block.
// Assumes ports are numbered 1 to 32 on each stack unit, copper first.
package spm_pkg;
  localparam int NPORT = 32;
  localparam int NTRUNK = 3;
  localparam int NMEMB = 4;
  localparam int NALL = NTRUNK * NMEMB;
  localparam logic [4:0] STACK_TRUNK_MAX = 5'h0c;
  localparam logic [2:0] UNIT_MIN = 3'h1;
  localparam logic [2:0] UNIT_MAX = 3'h7;
  localparam logic [2:0] MEMB_MIN = 3'h2;
  localparam logic [2:0] MEMB_MAX = 3'h4;
  localparam logic [2:0] FX_TRUNK_SIZE = 3'h2;
  localparam logic [5:0] PORT_FIRST = 6'h01;
  localparam logic [5:0] PORT_LAST = 6'h20;
  localparam logic [5:0] COPPER_LAST = 6'h18;
  localparam logic [5:0] GROUP_SPAN = 6'h0c;
  localparam logic [5:0] FIBRE_FIRST = 6'h19;
  localparam logic [1:0] MED_COPPER = 2'h0;
  localparam logic [1:0] MED_FX100 = 2'h1;
  localparam logic [1:0] MED_GIG = 2'h2;
  localparam logic [1:0] SPD_NONE = 2'h3;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SEC_NS = 1000000000;
  localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam logic [27:0] TICK_RESET = 28'h0000000;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_NOLINK = 3'h0,
    ST_BLOCK = 3'h1,
    ST_LISTEN = 3'h3,
    ST_LEARN = 3'h2,
    ST_FWD = 3'h6,
    ST_DIS = 3'h4
  } spm_state_type;
  localparam spm_state_type STATE_RESET = ST_BLOCK;
endpackage : spm_pkg

/* File: rtl/spm_port_ctrl.sv */
// Per-port spanning tree state, port mirroring and trunk checking for one stack unit.
// Assumes protocol decisions arrive as levels on the switch clock; link pins are async.
// Operation
// - Blocking port accepts configuration messages but forwards no data.
// - Listening port sends configuration messages, still forwards no data.
// - After one forward delay in listening, enter learning and clear address table.
// - Forwarding port forwards data and keeps learning addresses.
// - Port without valid link reports the no-link state.
// - Management disable or diagnostic failure puts the port in disabled.
// - At boot ports start blocked, then listen, learn, then forward.
// - Port alone on its segment always ends up forwarding.
// - Two own ports on one segment: lower number forwards, other blocks.
// - With mirroring on, target transmits a copy of source traffic.
// - One configuration bit switches mirroring on or off.
// - Exactly one source and target pair is mirrored.
// - Slower mirror target lowers the source port speed to match.
// - A trunk holds two to four member ports.
// - A port belongs to at most one trunk.
// - No trunk member may be mirror source or mirror target.
// - All trunk members share one media type.
// - Few trunks per switch, at most twelve across the stack.
// - A member names a stack unit one to seven and a port.
// - Copper members come from one internal switching group.
// - Fast fibre trunk is two ports on one module; gigabit anywhere.
// - All trunk ports share one spanning tree state.
// - Forward delay in seconds times listening and learning.
`timescale 1ns/1ps
`default_nettype none
module spm_port_ctrl #(
  parameter int unsigned SEC_CYCLES = spm_pkg::CYC_PER_SEC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [spm_pkg::NPORT-1:0] link_up_pin,
  input wire logic [spm_pkg::NPORT-1:0] port_mgmt_off,
  input wire logic [spm_pkg::NPORT-1:0] diag_fail,
  input wire logic [spm_pkg::NPORT-1:0] other_bridge_seen,
  input wire logic [spm_pkg::NPORT-1:0] lower_self_seen,
  input wire logic [spm_pkg::NPORT-1:0] role_forward,
  input wire logic [spm_pkg::NPORT-1:0] superior_info,
  input wire logic [7:0] forward_delay_s,
  input wire logic [2*spm_pkg::NPORT-1:0] port_media,
  input wire logic [2*spm_pkg::NPORT-1:0] port_speed,
  input wire logic mirror_en,
  input wire logic [5:0] mirror_src,
  input wire logic [5:0] mirror_tgt,
  input wire logic [2:0] my_unit,
  input wire logic [spm_pkg::NTRUNK-1:0] trunk_en,
  input wire logic [2*spm_pkg::NTRUNK-1:0] trunk_media,
  input wire logic [spm_pkg::NALL-1:0] memb_valid,
  input wire logic [3*spm_pkg::NALL-1:0] memb_unit,
  input wire logic [6*spm_pkg::NALL-1:0] memb_port,
  input wire logic [3:0] stack_other_trunks,
  output logic [3*spm_pkg::NPORT-1:0] port_state_ff,
  output logic [spm_pkg::NPORT-1:0] fwd_en_ff,
  output logic [spm_pkg::NPORT-1:0] learn_en_ff,
  output logic [spm_pkg::NPORT-1:0] bpdu_rx_en_ff,
  output logic [spm_pkg::NPORT-1:0] bpdu_tx_en_ff,
  output logic [spm_pkg::NPORT-1:0] addr_clear_ff,
  output logic [spm_pkg::NTRUNK-1:0] trunk_active_ff,
  output logic [spm_pkg::NTRUNK-1:0] trunk_bad_ff,
  output logic mirror_active_ff,
  output logic [spm_pkg::NPORT-1:0] mirror_copy_ff,
  output logic [spm_pkg::NPORT-1:0] mirror_watch_ff,
  output logic [2*spm_pkg::NPORT-1:0] speed_cap_ff
);
  import spm_pkg::*;

  function automatic logic [1:0] copper_group(input logic [5:0] num);
    logic [5:0] idx;
    idx = num - PORT_FIRST;
    if (idx >= GROUP_SPAN) begin
      idx = idx - GROUP_SPAN;
    end
    return idx[3:2];
  endfunction : copper_group

  function automatic logic fibre_module(input logic [5:0] num);
    logic [5:0] idx;
    idx = num - FIBRE_FIRST;
    return idx[2];
  endfunction : fibre_module

  function automatic logic port_ok(input logic [5:0] num);
    return (num >= PORT_FIRST) && (num <= PORT_LAST);
  endfunction : port_ok

  // -------------------------------------------------------------------------
  // Link synchronisers and the one-second tick
  // -------------------------------------------------------------------------
  logic [NPORT-1:0] link_meta_ff;
  logic [NPORT-1:0] link_ff;
  logic [27:0] tick_cnt_ff;
  logic sec_tick_ff;
  wire tick_wrap = (tick_cnt_ff == 28'(SEC_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_meta_ff <= '0;
      link_ff <= '0;
      tick_cnt_ff <= TICK_RESET;
      sec_tick_ff <= 1'b0;
    end else begin
      link_meta_ff <= link_up_pin;
      link_ff <= link_meta_ff;
      tick_cnt_ff <= tick_wrap ? TICK_RESET : tick_cnt_ff + 28'h0000001;
      sec_tick_ff <= tick_wrap;
    end
  end

  // -------------------------------------------------------------------------
  // Trunk checking
  // -------------------------------------------------------------------------
  // A trunk that breaks any placement limit is refused whole rather than
  // trimmed, so both ends of the link never disagree about its members.
  logic [NTRUNK-1:0] t_ok;
  logic [NTRUNK-1:0] t_act;
  logic [2:0] t_cnt [NTRUNK];
  logic [5:0] t_lead [NTRUNK];
  logic [4:0] stack_sum;

  always_comb begin
    logic [2:0] u;
    logic [5:0] p;
    logic [1:0] grp0;
    logic [2:0] unit0;
    logic mod0;
    logic first;
    u = 3'h0;
    p = 6'h00;
    grp0 = 2'h0;
    unit0 = 3'h0;
    mod0 = 1'b0;
    first = 1'b1;
    stack_sum = {1'b0, stack_other_trunks};
    for (int t = 0; t < NTRUNK; t++) begin
      t_cnt[t] = 3'h0;
      t_lead[t] = PORT_LAST;
      t_ok[t] = 1'b1;
      grp0 = 2'h0;
      unit0 = 3'h0;
      mod0 = 1'b0;
      first = 1'b1;
      for (int m = 0; m < NMEMB; m++) begin
        u = memb_unit[3*(t*NMEMB+m) +: 3];
        p = memb_port[6*(t*NMEMB+m) +: 6];
        if (memb_valid[t*NMEMB+m]) begin
          t_cnt[t] = t_cnt[t] + 3'h1;
          if (u < UNIT_MIN || u > UNIT_MAX || !port_ok(p)) begin
            t_ok[t] = 1'b0;
          end
          if (first) begin
            grp0 = copper_group(p);
            unit0 = u;
            mod0 = fibre_module(p);
            first = 1'b0;
          end
          if (trunk_media[2*t +: 2] == MED_COPPER &&
              (p > COPPER_LAST || copper_group(p) != grp0)) begin
            t_ok[t] = 1'b0;
          end
          if (trunk_media[2*t +: 2] == MED_FX100 &&
              (p < FIBRE_FIRST || u != unit0 || fibre_module(p) != mod0)) begin
            t_ok[t] = 1'b0;
          end
          if (trunk_media[2*t +: 2] == MED_GIG && p < FIBRE_FIRST) begin
            t_ok[t] = 1'b0;
          end
          if (u == my_unit && port_ok(p)) begin
            if (port_media[2*(p-PORT_FIRST) +: 2] != trunk_media[2*t +: 2]) begin
              t_ok[t] = 1'b0;
            end
            if (p < t_lead[t]) begin
              t_lead[t] = p;
            end
          end
          for (int k = 0; k < NALL; k++) begin
            if (k != t*NMEMB+m && memb_valid[k] && (k < t*NMEMB+m || k / NMEMB != t) &&
                memb_unit[3*k +: 3] == u && memb_port[6*k +: 6] == p) begin
              t_ok[t] = 1'b0;
            end
          end
        end
      end
      if (t_cnt[t] < MEMB_MIN || t_cnt[t] > MEMB_MAX) begin
        t_ok[t] = 1'b0;
      end
      if (trunk_media[2*t +: 2] == MED_FX100 && t_cnt[t] != FX_TRUNK_SIZE) begin
        t_ok[t] = 1'b0;
      end
      t_act[t] = 1'b0;
      if (trunk_en[t] && t_ok[t] && stack_sum < STACK_TRUNK_MAX) begin
        t_act[t] = 1'b1;
        stack_sum = stack_sum + 5'h01;
      end
    end
  end

  // Trunk ports follow the lowest-numbered local member of their trunk.
  logic [4:0] eff_idx [NPORT];
  logic [NPORT-1:0] in_trunk;

  always_comb begin
    for (int q = 0; q < NPORT; q++) begin
      eff_idx[q] = 5'(q);
      in_trunk[q] = 1'b0;
      for (int k = 0; k < NALL; k++) begin
        if (t_act[k / NMEMB] && memb_valid[k] && memb_unit[3*k +: 3] == my_unit &&
            memb_port[6*k +: 6] == 6'(q + 1)) begin
          in_trunk[q] = 1'b1;
          eff_idx[q] = 5'(t_lead[k / NMEMB] - PORT_FIRST);
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Mirroring
  // -------------------------------------------------------------------------
  // Trunks win over the mirror: a clashing mirror pair is simply not applied.
  wire [4:0] src_idx = 5'(mirror_src - PORT_FIRST);
  wire [4:0] tgt_idx = 5'(mirror_tgt - PORT_FIRST);
  wire mirror_ok = mirror_en && port_ok(mirror_src) && port_ok(mirror_tgt) &&
                   (mirror_src != mirror_tgt) && !in_trunk[src_idx] && !in_trunk[tgt_idx];
  wire [1:0] src_spd = port_speed[2*src_idx +: 2];
  wire [1:0] tgt_spd = port_speed[2*tgt_idx +: 2];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mirror_active_ff <= 1'b0;
      mirror_copy_ff <= '0;
      mirror_watch_ff <= '0;
      speed_cap_ff <= '1;
      trunk_active_ff <= '0;
      trunk_bad_ff <= '0;
    end else begin
      mirror_active_ff <= mirror_ok;
      mirror_copy_ff <= mirror_ok ? (NPORT'(1) << tgt_idx) : '0;
      mirror_watch_ff <= mirror_ok ? (NPORT'(1) << src_idx) : '0;
      speed_cap_ff <= '1;
      if (mirror_ok && tgt_spd < src_spd) begin
        speed_cap_ff[2*src_idx +: 2] <= tgt_spd;
      end
      trunk_active_ff <= t_act;
      trunk_bad_ff <= trunk_en & ~t_act;
    end
  end

  // -------------------------------------------------------------------------
  // Spanning tree port state machines
  // -------------------------------------------------------------------------
  spm_state_type state_ff [NPORT];
  logic [7:0] timer_ff [NPORT];

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    // Alone on the segment, or the lower of two own ports, the port may go on.
    wire go = (!other_bridge_seen[g] && !lower_self_seen[g]) || role_forward[g];
    wire expired = (timer_ff[g] == TIMER_RESET);
    spm_state_type nxt_state;
    always_comb begin
      nxt_state = state_ff[g];
      if (!link_ff[g]) begin
        nxt_state = ST_NOLINK;
      end else if (port_mgmt_off[g] || diag_fail[g]) begin
        nxt_state = ST_DIS;
      end else begin
        case (state_ff[g])
          ST_NOLINK, ST_DIS: nxt_state = ST_BLOCK;
          ST_BLOCK: if (go) nxt_state = ST_LISTEN;
          ST_LISTEN: begin
            if (!go || superior_info[g]) nxt_state = ST_BLOCK;
            else if (expired) nxt_state = ST_LEARN;
          end
          ST_LEARN: begin
            if (!go || superior_info[g]) nxt_state = ST_BLOCK;
            else if (expired) nxt_state = ST_FWD;
          end
          ST_FWD: if (!go) nxt_state = ST_BLOCK;
          default: nxt_state = ST_BLOCK;
        endcase
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        state_ff[g] <= STATE_RESET;
        timer_ff[g] <= TIMER_RESET;
      end else begin
        state_ff[g] <= nxt_state;
        if (nxt_state != state_ff[g]) begin
          timer_ff[g] <= forward_delay_s;
        end else if (sec_tick_ff && !expired) begin
          timer_ff[g] <= timer_ff[g] - 8'h01;
        end
      end
    end
    wire [2:0] eff = state_ff[eff_idx[g]];
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        port_state_ff[3*g +: 3] <= STATE_RESET;
        fwd_en_ff[g] <= 1'b0;
        learn_en_ff[g] <= 1'b0;
        bpdu_rx_en_ff[g] <= 1'b1;
        bpdu_tx_en_ff[g] <= 1'b0;
        addr_clear_ff[g] <= 1'b0;
      end else begin
        port_state_ff[3*g +: 3] <= eff;
        fwd_en_ff[g] <= (eff == ST_FWD);
        learn_en_ff[g] <= (eff == ST_LEARN) || (eff == ST_FWD);
        bpdu_rx_en_ff[g] <= (eff != ST_NOLINK) && (eff != ST_DIS);
        bpdu_tx_en_ff[g] <= (eff == ST_LISTEN) || (eff == ST_LEARN) || (eff == ST_FWD);
        addr_clear_ff[g] <= (eff == ST_LEARN) && (port_state_ff[3*g +: 3] != ST_LEARN);
      end
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [2:0] ps0 = port_state_ff[2:0];

  a_block_no_fwd: assert property (ps0 == ST_BLOCK |-> !fwd_en_ff[0] && bpdu_rx_en_ff[0])
    else $error("blocking port forwards");
  a_listen_tx_only: assert property (ps0 == ST_LISTEN |-> bpdu_tx_en_ff[0] && !fwd_en_ff[0])
    else $error("listening port outputs wrong");
  a_learn_clears: assert property (ps0 == ST_LEARN && $past(ps0) != ST_LEARN |-> addr_clear_ff[0])
    else $error("no address clear on learning");
  a_fwd_learns: assert property (ps0 == ST_FWD |-> fwd_en_ff[0] && learn_en_ff[0])
    else $error("forwarding port not active");
  a_nolink_state: assert property (!link_ff[0] |=> state_ff[0] == ST_NOLINK)
    else $error("no-link not reported");
  a_disable_state: assert property (link_ff[0] && port_mgmt_off[0] |=> state_ff[0] == ST_DIS)
    else $error("disable not applied");
  a_boot_order: assert property (state_ff[0] == ST_FWD && $past(state_ff[0]) != ST_FWD
                                 |-> $past(state_ff[0]) == ST_LEARN)
    else $error("forwarding not entered from learning");
  a_mirror_pair: assert property (mirror_active_ff |-> $onehot(mirror_copy_ff) &&
                                  $onehot(mirror_watch_ff) && mirror_copy_ff != mirror_watch_ff)
    else $error("mirror pair not single");
  a_mirror_off: assert property (!mirror_en |=> !mirror_active_ff && mirror_copy_ff == '0)
    else $error("mirror active while off");
  a_trunk_size: assert property (trunk_active_ff[0] |-> $past(t_cnt[0]) >= MEMB_MIN &&
                                 $past(t_cnt[0]) <= MEMB_MAX)
    else $error("trunk size out of range");
  a_trunk_count: assert property ((trunk_active_ff[0] + trunk_active_ff[1] + trunk_active_ff[2] +
                                   $past(stack_other_trunks)) <= STACK_TRUNK_MAX)
    else $error("too many trunks in stack");
endmodule : spm_port_ctrl
`default_nettype wire

/* File: verification/spm_nbr_model.sv */
// Model of the bridges that share each port's segment, as the protocol engine reports them.
// Assumes the testbench picks, per port, whether a peer bridge or an own twin port is present.
`timescale 1ns/1ps
`default_nettype none
module spm_nbr_model (
  input wire logic clk,
  input wire logic [31:0] peer_on,
  input wire logic [31:0] twin_on,
  input wire logic [31:0] peer_yield,
  input wire logic [31:0] sup_on,
  output logic [31:0] other_bridge_seen,
  output logic [31:0] lower_self_seen,
  output logic [31:0] role_forward,
  output logic [31:0] superior_info
);
  // ----------------------------------------
  // Segment view, changed only after the falling edge
  // ----------------------------------------
  // A quiet segment reports nothing, so the port is free to forward.
  always @(negedge clk) begin
    other_bridge_seen <= peer_on;
    lower_self_seen <= twin_on;
    role_forward <= peer_yield;
    superior_info <= sup_on;
  end
endmodule : spm_nbr_model
`default_nettype wire

/* File: verification/spm_port_ctrl_tb_top.sv */
// Testbench for the per-port state, mirror and trunk block.
// Assumes a shortened second of four cycles and a forward delay of one second.
`timescale 1ns/1ps
`default_nettype none
module spm_port_ctrl_tb_top;
  import spm_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] link = '1, off = '0, diag = '0, peer = '0, twin = '0, yld = '0, contra = '0;
  logic [31:0] obs, lss, rf, sup;
  logic [63:0] media, speed;
  logic men = 1'b0;
  logic [5:0] msrc = 6'h01, mtgt = 6'h02;
  logic [2:0] ten = '0;
  logic [5:0] tmed = '0;
  logic [11:0] mval = '0;
  logic [35:0] munit = '0;
  logic [71:0] mport = '0;
  logic [3:0] oth = '0;
  logic [95:0] pst;
  logic [31:0] fwd, lrn, brx, btx, aclr, mcopy, mwatch;
  logic [2:0] tact, tbad;
  logic mact;
  logic [63:0] cap;
  int num_errors = 0;
  int checks = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  spm_nbr_model nbr (.clk(clk), .peer_on(peer), .twin_on(twin), .peer_yield(yld),
    .sup_on(contra), .other_bridge_seen(obs), .lower_self_seen(lss), .role_forward(rf),
    .superior_info(sup));
  spm_port_ctrl #(.SEC_CYCLES(4)) uut (.clk(clk), .reset_n(reset_n), .link_up_pin(link),
    .port_mgmt_off(off), .diag_fail(diag), .other_bridge_seen(obs), .lower_self_seen(lss),
    .role_forward(rf), .superior_info(sup), .forward_delay_s(8'h01), .port_media(media),
    .port_speed(speed), .mirror_en(men), .mirror_src(msrc), .mirror_tgt(mtgt),
    .my_unit(3'h1), .trunk_en(ten), .trunk_media(tmed), .memb_valid(mval),
    .memb_unit(munit), .memb_port(mport), .stack_other_trunks(oth), .port_state_ff(pst),
    .fwd_en_ff(fwd), .learn_en_ff(lrn), .bpdu_rx_en_ff(brx), .bpdu_tx_en_ff(btx),
    .addr_clear_ff(aclr), .trunk_active_ff(tact), .trunk_bad_ff(tbad),
    .mirror_active_ff(mact), .mirror_copy_ff(mcopy), .mirror_watch_ff(mwatch),
    .speed_cap_ff(cap));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // Polls at falling edges so the state and its enables are settled when looked at.
  task automatic wait_st(input int q, input spm_state_type st, input string msg);
    int n;
    n = 0;
    while (pst[3*q +: 3] !== st && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(pst[3*q +: 3] === st, msg);
  endtask : wait_st
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic boot_walk();
    wait_st(0, ST_LISTEN, "no listening");
    chk(btx[0] === 1'b1 && fwd[0] === 1'b0, "listening enables");
    wait_st(0, ST_LEARN, "no learning");
    chk(aclr[0] === 1'b1 && lrn[0] === 1'b1 && fwd[0] === 1'b0, "learning entry");
    @(negedge clk);
    chk(aclr[0] === 1'b0, "address clear not a pulse");
    wait_st(0, ST_FWD, "no forwarding");
    chk(fwd[0] === 1'b1 && lrn[0] === 1'b1, "forwarding enables");
    wait_st(6, ST_FWD, "quiet segment port not forwarding");
  endtask : boot_walk
  task automatic port_faults();
    link[1] = 1'b0;
    off[0] = 1'b1;
    off[2] = 1'b1;
    diag[3] = 1'b1;
    twin[5] = 1'b1;
    wait_st(1, ST_NOLINK, "lost link not nolink");
    wait_st(2, ST_DIS, "management off not disabled");
    wait_st(0, ST_DIS, "management off port zero not disabled");
    wait_st(3, ST_DIS, "diagnostic fail not disabled");
    wait_st(5, ST_BLOCK, "twin port not blocked");
    chk(brx[5] === 1'b1 && fwd[5] === 1'b0, "blocking enables");
    link[1] = 1'b1;
    off[0] = 1'b0;
    off[2] = 1'b0;
    diag[3] = 1'b0;
    twin[5] = 1'b0;
    wait_st(5, ST_LISTEN, "freed twin port not listening");
    contra[5] = 1'b1;
    wait_st(5, ST_BLOCK, "superior information ignored");
    chk(fwd[5] === 1'b0, "forwarding despite superior information");
    contra[5] = 1'b0;
  endtask : port_faults
  task automatic mirror_case();
    msrc = 6'h03;
    mtgt = 6'h05;
    men = 1'b1;
    settle();
    chk(mact === 1'b1 && mcopy === 32'h00000010, "mirror target copy");
    chk(mwatch === 32'h00000004, "mirror source watch");
    chk(cap[5:4] === 2'h0 && cap[9:8] === 2'h3, "source speed not capped");
    mtgt = 6'h03;
    settle();
    chk(mact === 1'b0 && mcopy === 32'h00000000, "same port pair accepted");
    mtgt = 6'h05;
    men = 1'b0;
    settle();
    chk(mact === 1'b0 && mwatch === 32'h00000000, "mirror still on");
  endtask : mirror_case
  // Trunk zero with two members; member b may sit on another unit.
  task automatic trunk_case(input logic [1:0] med, input logic [5:0] pa, input logic [5:0] pb,
      input logic [2:0] ub, input logic [3:0] others, input logic ok, input string msg);
    tmed[1:0] = med;
    mval[1:0] = 2'h3;
    munit[5:0] = {ub, 3'h1};
    mport[11:0] = {pb, pa};
    oth = others;
    ten[0] = 1'b1;
    settle();
    chk(tact[0] === ok && tbad[0] === !ok, msg);
  endtask : trunk_case
  task automatic trunks();
    trunk_case(MED_COPPER, 6'h01, 6'h0d, 3'h1, 4'h0, 1'b1, "copper group trunk");
    trunk_case(MED_COPPER, 6'h01, 6'h05, 3'h1, 4'h0, 1'b0, "cross group trunk");
    trunk_case(MED_FX100, 6'h19, 6'h1a, 3'h1, 4'h0, 1'b1, "fibre pair trunk");
    trunk_case(MED_FX100, 6'h19, 6'h1d, 3'h1, 4'h0, 1'b0, "fibre two modules");
    trunk_case(MED_GIG, 6'h1d, 6'h1e, 3'h3, 4'h0, 1'b1, "gigabit remote trunk");
    trunk_case(MED_COPPER, 6'h01, 6'h19, 3'h1, 4'h0, 1'b0, "mixed media trunk");
    trunk_case(MED_COPPER, 6'h01, 6'h0d, 3'h0, 4'h0, 1'b0, "unit zero accepted");
    trunk_case(MED_COPPER, 6'h01, 6'h0d, 3'h1, 4'hc, 1'b0, "stack limit passed");
    trunk_case(MED_COPPER, 6'h01, 6'h0d, 3'h1, 4'hb, 1'b1, "stack limit too low");
    mval[1] = 1'b0;
    settle();
    chk(tbad[0] === 1'b1 && tact[0] === 1'b0, "single member trunk");
    mval[1] = 1'b1;
    tmed[3:2] = MED_COPPER;
    mval[5:4] = 2'h3;
    munit[17:12] = 6'h09;
    mport[35:24] = {6'h0d, 6'h02};
    ten[1] = 1'b1;
    settle();
    chk(tact[0] === 1'b0 && tbad[0] === 1'b1 && tbad[1] === 1'b1, "port in two trunks");
    ten[1] = 1'b0;
    mval[5:4] = 2'h0;
    twin[12] = 1'b1;
    settle();
    chk(pst[38:36] === ST_FWD, "member not sharing leader state");
    twin[12] = 1'b0;
    msrc = 6'h0d;
    men = 1'b1;
    settle();
    chk(mact === 1'b0 && tact[0] === 1'b1, "trunk member mirrored");
    men = 1'b0;
  endtask : trunks
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    for (int q = 0; q < 32; q++) begin
      media[2*q +: 2] = q < 24 ? MED_COPPER : (q < 28 ? MED_FX100 : MED_GIG);
      speed[2*q +: 2] = q == 4 ? 2'h0 : 2'h1;
    end
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    boot_walk();
    port_faults();
    mirror_case();
    trunks();
    stop_test();
  end
  // The whole sequence needs under a hundred cycles; this limit is far above that.
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : spm_port_ctrl_tb_top
`default_nettype wire
